// ### common/dopio_defs.vh
`ifndef DOPIO_DEFS_VH
`define DOPIO_DEFS_VH
// register indices on the plain register port
`define DOPIO_ADDR_W 3
`define DOPIO_REG_P2_DIR 3'h0
`define DOPIO_REG_P2_DATA 3'h1
`define DOPIO_REG_P2_PULL 3'h2
`define DOPIO_REG_P3_DIR 3'h3
`define DOPIO_REG_P3_DATA 3'h4
`define DOPIO_REG_P3_PULL 3'h5
`define DOPIO_REG_HOST_CTRL 3'h6
// host interface control field positions
`define DOPIO_HCH1_BIT 0
`define DOPIO_HCH2_BIT 1
`define DOPIO_HCH3_BIT 2
// reset values
`define DOPIO_RST_BYTE 8'h00
`define DOPIO_RST_HOST 3'h0
// host bus pin positions on the third port
`define DOPIO_HB_SERIRQ 7
`define DOPIO_HB_CLK 6
`define DOPIO_HB_RESET 5
`define DOPIO_HB_FRAME 4
`endif

// ### design/dopio_port_pin.v
// ----------------------------------------
// one 8-bit port: pad drive, pull-up, read-back
// ----------------------------------------
module dopio_port_pin #(
  parameter WIDTH = 8
) (
  input wire [WIDTH-1:0] dir_i,
  input wire [WIDTH-1:0] data_i,
  input wire [WIDTH-1:0] pull_ctrl_i,
  input wire [WIDTH-1:0] pin_in_i,
  input wire pull_allow_i,
  output wire [WIDTH-1:0] pin_oe_o,
  output wire [WIDTH-1:0] pin_out_o,
  output wire [WIDTH-1:0] pull_en_o,
  output wire [WIDTH-1:0] read_o
);
  assign pin_oe_o = dir_i;
  assign pin_out_o = data_i;
  assign pull_en_o = {WIDTH{pull_allow_i}} & ~dir_i & pull_ctrl_i;
  assign read_o = (dir_i & data_i) | (~dir_i & pin_in_i);
endmodule

// ### design/dopio_top.v
//
// Function
// - a second-port input pin has its pull-up on while its pull-up control bit is 1.
// - a second-port pin is an input with direction 0 and an output with direction 1.
// - second-port pull-ups are off in reset and hardware standby, else on only for direction 0 and control 1.
// - each pin's pull-up is chosen on its own through its pull-up control bit.
// - the third-port direction register is write-only, 1 makes an output, 0 an input.
// - third-port data reads give the stored bit for outputs and the pin level for inputs.
// - a third-port input pin has its pull-up on while its pull-up control bit is 1.
// - third-port pull-ups are unusable while the host bus interface is enabled.
// - with all host-channel enables 0 the third port is general I/O, otherwise it serves the host bus.
// - in host bus mode pins 7..0 are serial irq, bus clock, bus reset, frame, address/data 3..0.
// - host bus pin mode starts as soon as any host-channel enable is 1.
// - third-port pull-ups are off in reset and hardware standby, else on only for direction 0 and control 1.
// - second-port direction 1 makes an output and 0 an input.
// - second-port data reads give the stored bit for outputs and the pin level for inputs.
//
// Added by the designer: the register addresses and the address-and-strobe port.
`include "dopio_defs.vh"
module dopio_top #(
  parameter WIDTH = 8
) (
  input wire core_clk_i,
  input wire reset_i,
  input wire clk_en_i,
  input wire hw_standby_i,
  input wire [`DOPIO_ADDR_W-1:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [7:0] reg_rdata_o,
  input wire [WIDTH-1:0] p2_pin_i,
  output reg [WIDTH-1:0] p2_pin_o,
  output reg [WIDTH-1:0] p2_pin_oe_o,
  output reg [WIDTH-1:0] p2_pull_en_o,
  input wire [WIDTH-1:0] p3_pin_i,
  output reg [WIDTH-1:0] p3_pin_o,
  output reg [WIDTH-1:0] p3_pin_oe_o,
  output reg [WIDTH-1:0] p3_pull_en_o,
  output reg host_bus_mode_o,
  output reg [WIDTH-1:0] host_pin_o
);
  // ----------------------------------------
  // registers
  // ----------------------------------------
  reg [WIDTH-1:0] port_two_direction;
  reg [WIDTH-1:0] port_two_output_data;
  reg [WIDTH-1:0] port_two_pullup_ctrl;
  reg [WIDTH-1:0] port_three_direction;
  reg [WIDTH-1:0] port_three_output_data;
  reg [WIDTH-1:0] port_three_pullup_ctrl;
  reg host_channel_one_enable;
  reg host_channel_two_enable;
  reg host_channel_three_enable;

  wire host_mode;
  wire [WIDTH-1:0] p2_oe;
  wire [WIDTH-1:0] p2_out;
  wire [WIDTH-1:0] p2_pull;
  wire [WIDTH-1:0] p2_read;
  wire [WIDTH-1:0] p3_oe;
  wire [WIDTH-1:0] p3_out;
  wire [WIDTH-1:0] p3_pull;
  wire [WIDTH-1:0] p3_read;
  reg [7:0] next_rdata;

  function [7:0] dopio_pad;
    input [WIDTH-1:0] v;
    begin
      dopio_pad = 8'h00;
      dopio_pad[WIDTH-1:0] = v;
    end
  endfunction

  // any channel enable hands port 3 to the host bus
  assign host_mode = host_channel_one_enable | host_channel_two_enable | host_channel_three_enable;

  always @(posedge core_clk_i) begin
    if (reset_i) begin
      port_two_direction <= {WIDTH{1'b0}};
      port_two_output_data <= {WIDTH{1'b0}};
      port_two_pullup_ctrl <= {WIDTH{1'b0}};
      port_three_direction <= {WIDTH{1'b0}};
      port_three_output_data <= {WIDTH{1'b0}};
      port_three_pullup_ctrl <= {WIDTH{1'b0}};
      host_channel_one_enable <= 1'b0;
      host_channel_two_enable <= 1'b0;
      host_channel_three_enable <= 1'b0;
    end else if (clk_en_i && reg_wr_i) begin
      case (reg_addr_i)
        `DOPIO_REG_P2_DIR: port_two_direction <= reg_wdata_i[WIDTH-1:0];
        `DOPIO_REG_P2_DATA: port_two_output_data <= reg_wdata_i[WIDTH-1:0];
        `DOPIO_REG_P2_PULL: port_two_pullup_ctrl <= reg_wdata_i[WIDTH-1:0];
        `DOPIO_REG_P3_DIR: port_three_direction <= reg_wdata_i[WIDTH-1:0];
        `DOPIO_REG_P3_DATA: port_three_output_data <= reg_wdata_i[WIDTH-1:0];
        `DOPIO_REG_P3_PULL: port_three_pullup_ctrl <= reg_wdata_i[WIDTH-1:0];
        `DOPIO_REG_HOST_CTRL: begin
          host_channel_one_enable <= reg_wdata_i[`DOPIO_HCH1_BIT];
          host_channel_two_enable <= reg_wdata_i[`DOPIO_HCH2_BIT];
          host_channel_three_enable <= reg_wdata_i[`DOPIO_HCH3_BIT];
        end
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // pin logic
  // ----------------------------------------
  dopio_port_pin #(.WIDTH(WIDTH)) u_p2 (
    .dir_i(port_two_direction),
    .data_i(port_two_output_data),
    .pull_ctrl_i(port_two_pullup_ctrl),
    .pin_in_i(p2_pin_i),
    .pull_allow_i(~hw_standby_i),
    .pin_oe_o(p2_oe),
    .pin_out_o(p2_out),
    .pull_en_o(p2_pull),
    .read_o(p2_read)
  );

  // host mode masks direction: host bus owns the pad, pull-ups unusable
  dopio_port_pin #(.WIDTH(WIDTH)) u_p3 (
    .dir_i(port_three_direction & {WIDTH{~host_mode}}),
    .data_i(port_three_output_data),
    .pull_ctrl_i(port_three_pullup_ctrl),
    .pin_in_i(p3_pin_i),
    .pull_allow_i(~hw_standby_i & ~host_mode),
    .pin_oe_o(p3_oe),
    .pin_out_o(p3_out),
    .pull_en_o(p3_pull),
    .read_o(p3_read)
  );

  // ----------------------------------------
  // read port
  // ----------------------------------------
  always @* begin
    next_rdata = 8'h00;
    case (reg_addr_i)
      `DOPIO_REG_P2_DATA: next_rdata = dopio_pad(p2_read);
      `DOPIO_REG_P2_PULL: next_rdata = dopio_pad(port_two_pullup_ctrl);
      `DOPIO_REG_P3_DATA: next_rdata = dopio_pad(p3_read);
      `DOPIO_REG_P3_PULL: next_rdata = dopio_pad(port_three_pullup_ctrl);
      `DOPIO_REG_HOST_CTRL: begin
        next_rdata[`DOPIO_HCH1_BIT] = host_channel_one_enable;
        next_rdata[`DOPIO_HCH2_BIT] = host_channel_two_enable;
        next_rdata[`DOPIO_HCH3_BIT] = host_channel_three_enable;
      end
      // direction registers are write-only and read as zero
      default: next_rdata = 8'h00;
    endcase
  end

  // ----------------------------------------
  // output flops; pins registered, one cycle behind registers
  // ----------------------------------------
  always @(posedge core_clk_i) begin
    if (reset_i) begin
      reg_rdata_o <= 8'h00;
      p2_pin_o <= {WIDTH{1'b0}};
      p2_pin_oe_o <= {WIDTH{1'b0}};
      p2_pull_en_o <= {WIDTH{1'b0}};
      p3_pin_o <= {WIDTH{1'b0}};
      p3_pin_oe_o <= {WIDTH{1'b0}};
      p3_pull_en_o <= {WIDTH{1'b0}};
      host_bus_mode_o <= 1'b0;
      host_pin_o <= {WIDTH{1'b0}};
    end else if (clk_en_i) begin
      reg_rdata_o <= reg_rd_i ? next_rdata : 8'h00;
      p2_pin_o <= p2_out;
      p2_pin_oe_o <= p2_oe;
      p2_pull_en_o <= p2_pull;
      p3_pin_o <= p3_out;
      p3_pin_oe_o <= p3_oe;
      p3_pull_en_o <= p3_pull;
      host_bus_mode_o <= host_mode;
      // pins pass straight to host controller: serirq, clk, reset, frame, ad3..0
      host_pin_o <= host_mode ? p3_pin_i : {WIDTH{1'b0}};
    end
  end
endmodule

// ### tb/dopio_pin_model.sv
module dopio_pin_model (
  input wire logic clk_i,
  input wire logic [7:0] oe_i, out_i, pull_i, drv_i, ext_i,
  output logic [7:0] pin_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic t = 1'b0;
  // floating pins wander so no read passes by luck
  always @(posedge clk_i) t <= ~t;
  assign pin_o = (oe_i & out_i) | (~oe_i & drv_i & ext_i) | (~oe_i & ~drv_i & (pull_i | {8{t}}));
endmodule

// ### tb/dopio_props.sv
`include "dopio_defs.vh"
module dopio_props #(
  parameter WIDTH = 8
) (
  input wire logic core_clk_i, reset_i, hw_standby_i, reg_wr_i, reg_rd_i, host_bus_mode_o,
  input wire logic [2:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i, reg_rdata_o,
  input wire logic [WIDTH-1:0] p2_pin_oe_o, p2_pull_en_o, p3_pin_i, p3_pin_o, p3_pin_oe_o, p3_pull_en_o, host_pin_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------
  // checks
  // ----------
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  rst_clear_a: assert property ($fell(reset_i) |-> !(p2_pin_oe_o | p3_pin_oe_o | p2_pull_en_o | p3_pull_en_o))
    else $error("pins not clear after reset");
  stby_pull_a: assert property (hw_standby_i |=> !(p2_pull_en_o | p3_pull_en_o))
    else $error("pull-up on in standby");
  p2_pull_a: assert property (!(p2_pull_en_o & p2_pin_oe_o))
    else $error("pull-up on an output");
  p3_pull_a: assert property (!(p3_pull_en_o & p3_pin_oe_o))
    else $error("pull-up on an output");
  host_pins_a: assert property (host_bus_mode_o |-> !(p3_pin_oe_o | p3_pull_en_o))
    else $error("port drive in host mode");
  host_map_a: assert property (host_bus_mode_o && $past(host_bus_mode_o) |-> host_pin_o == $past(p3_pin_i))
    else $error("host pins not mapped");
  dir_read_a: assert property (reg_rd_i && reg_addr_i == `DOPIO_REG_P3_DIR |=> reg_rdata_o == 8'h00)
    else $error("direction readable");
  p2_dir_a: assert property (reg_wr_i && reg_addr_i == `DOPIO_REG_P2_DIR |-> ##2 p2_pin_oe_o == $past(reg_wdata_i, 2))
    else $error("direction not applied");
  p3_data_a: assert property (reg_wr_i && reg_addr_i == `DOPIO_REG_P3_DATA |-> ##2 p3_pin_o == $past(reg_wdata_i, 2))
    else $error("data not applied");
  host_on_a: assert property (reg_wr_i && reg_addr_i == `DOPIO_REG_HOST_CTRL |->
    ##2 host_bus_mode_o == (($past(reg_wdata_i, 2) & 8'h07) != 8'h00))
    else $error("host mode wrong");
  cover property (host_bus_mode_o);
  cover property (hw_standby_i ##1 !hw_standby_i);
  cover property (|p3_pull_en_o);
endmodule
bind dopio_top dopio_props #(.WIDTH(WIDTH)) u_props (.*);

// ### tb/dopio_top_tb.sv
module dopio_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst = 1, stby = 0, wr = 0, rd = 0, hmode;
  logic [2:0] addr = 0;
  logic [7:0] wd = 0, rdata, p2_in, p2_o, p2_oe, p2_pu, p3_in, p3_o, p3_oe, p3_pu, hpin;
  logic [7:0] d2 = 8'hff, e2 = 8'h3c, d3 = 8'hff, e3 = 8'hc3;
  int error_cnt = 0, n_compared = 0;
  dopio_top u_dut (.core_clk_i(clk), .reset_i(rst), .clk_en_i(1'b1), .hw_standby_i(stby), .reg_addr_i(addr),
    .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .p2_pin_i(p2_in), .p2_pin_o(p2_o),
    .p2_pin_oe_o(p2_oe), .p2_pull_en_o(p2_pu), .p3_pin_i(p3_in), .p3_pin_o(p3_o), .p3_pin_oe_o(p3_oe),
    .p3_pull_en_o(p3_pu), .host_bus_mode_o(hmode), .host_pin_o(hpin));
  dopio_pin_model u_p2 (.clk_i(clk), .oe_i(p2_oe), .out_i(p2_o), .pull_i(p2_pu), .drv_i(d2), .ext_i(e2), .pin_o(p2_in));
  dopio_pin_model u_p3 (.clk_i(clk), .oe_i(p3_oe), .out_i(p3_o), .pull_i(p3_pu), .drv_i(d3), .ext_i(e3), .pin_o(p3_in));
  initial forever #25 clk = ~clk;
  // ----------
  // tasks
  // ----------
  task chk(input [7:0] s, input [7:0] e);
    n_compared++;
    if (s !== e) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task wreg(input [2:0] a, input [7:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task rchk(input [2:0] a, input [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    // read data stand only until the next rising edge
    @(negedge clk);
    chk(rdata, e);
  endtask
  task settle;
    repeat (3) @(posedge clk);
  endtask
  task t_reset;
    wreg(3'h7, 8'hff);
    for (int i = 0; i < 8; i++) rchk(i[2:0], i == 1 ? 8'h3c : i == 4 ? 8'hc3 : 8'h00);
  endtask
  task t_port2;
    d2 <= 8'h30;
    e2 <= 8'h00;
    wreg(3'h0, 8'h0f);
    wreg(3'h1, 8'ha5);
    wreg(3'h2, 8'hf0);
    settle;
    chk(p2_oe, 8'h0f);
    chk(p2_o, 8'ha5);
    chk(p2_pu, 8'hf0);
    rchk(3'h1, 8'hc5);
    rchk(3'h2, 8'hf0);
    stby <= 1'b1;
    settle;
    chk(p2_pu, 8'h00);
    stby <= 1'b0;
    settle;
    chk(p2_pu, 8'hf0);
  endtask
  task t_port3;
    d3 <= 8'h00;
    wreg(3'h3, 8'h3c);
    wreg(3'h4, 8'h5a);
    wreg(3'h5, 8'hff);
    settle;
    chk(p3_oe, 8'h3c);
    chk(p3_o, 8'h5a);
    chk(p3_pu, 8'hc3);
    rchk(3'h4, 8'hdb);
    rchk(3'h3, 8'h00);
    stby <= 1'b1;
    settle;
    chk(p3_pu, 8'h00);
    stby <= 1'b0;
  endtask
  task t_host;
    wreg(3'h3, 8'h00);
    d3 <= 8'hff;
    e3 <= 8'h96;
    for (int c = 0; c < 3; c++) begin
      wreg(3'h6, 8'h01 << c);
      settle;
      chk({7'h00, hmode}, 8'h01);
      chk(p3_pu | p3_oe, 8'h00);
      chk(hpin, 8'h96);
    end
    wreg(3'h6, 8'h00);
    settle;
    chk({7'h00, hmode}, 8'h00);
    chk(p3_pu, 8'hff);
  endtask
  task print_verdict;
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_port2;
    t_port3;
    t_host;
    print_verdict;
  end
endmodule
